// ---- common/fbp_pkg.sv ----
// How it works
// RULE_01: four two-way bits at positions 7..4; only bit 4 reaches a package pin.
// RULE_02: bit 7 transmit, bit 6 chip select, bit 5 receive, internal transceiver only.
// RULE_03: software programs direction as 001x 0000, bit 4 free.
// RULE_04: software clears direction bits 7,6 and sets bit 5.
// RULE_05: direction 1 tri-states the general pin; 0 drives it.
// RULE_06: output latch is mapped; read-modify-write uses latch, not pin.
// RULE_07: port write updates latch; port read returns synchronised line levels.
// RULE_08: analog select 1 forces digital reads of that bit to 0.
// RULE_09: analog select never affects driving; direction 0 still drives latch.
// RULE_10: analog select resets to all ones, so bits read 0 after reset.
// RULE_11: software clears analog select bits 7..5.
// RULE_12: analog select bit 4 disables general pin input buffer.
// RULE_13: pull-up enable bit active only while global pull-up disable is low.
// RULE_14: pull-up off whenever the bit is an output.
// RULE_15: threshold bit 1 picks Schmitt input, 0 picks TTL input.
// RULE_16: bits 3..0 of every register read as 0.
// RULE_17: suggested init: latch 0c0, then direction 030.
// RULE_18: writes act on completing edge; inputs synchronised before read.
package fbp_pkg;
    // ****************************************
    // register map, byte addresses of our choosing
    // ****************************************
    localparam logic [4:0] FBP_OFS_PORT  = 5'h00;
    localparam logic [4:0] FBP_OFS_DIR   = 5'h04;
    localparam logic [4:0] FBP_OFS_LAT   = 5'h08;
    localparam logic [4:0] FBP_OFS_ANSEL = 5'h0c;
    localparam logic [4:0] FBP_OFS_PULL  = 5'h10;
    localparam logic [4:0] FBP_OFS_THR   = 5'h14;
    localparam int         FBP_ADDR_W    = 5;
    // ****************************************
    // field and reset values
    // ****************************************
    localparam int         FBP_LSB       = 4;
    localparam logic [3:0] FBP_RST_DIR   = 4'hf;
    localparam logic [3:0] FBP_RST_LAT   = 4'h0;
    localparam logic [3:0] FBP_RST_ANSEL = 4'hf;
    localparam logic [3:0] FBP_RST_PULL  = 4'hf;
    localparam logic [3:0] FBP_RST_THR   = 4'h0;
    localparam logic [1:0] FBP_RESP_OK   = 2'h0;
    localparam logic [1:0] FBP_RESP_ERR  = 2'h2;

    typedef struct packed {
        logic [3:0] dir;
        logic [3:0] lat;
        logic [3:0] ansel;
        logic [3:0] pull;
        logic [3:0] thr;
    } fbp_cfg_t;

    // place a four-bit field in bits 7..4 of a word, rest zero
    function automatic logic [31:0] fbp_word(input logic [3:0] f);
        fbp_word = {24'h000000, f, 4'h0};
    endfunction
endpackage

// ---- rtl/fbp_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module fbp_port
    import fbp_pkg::*;
(
    // clock and reset
    input  wire  logic        aclk,
    input  wire  logic        aresetn,
    // axi4-lite write
    input  wire  logic [31:0] s_axi_awaddr,
    input  wire  logic        s_axi_awvalid,
    output var   logic        s_axi_awready,
    input  wire  logic [31:0] s_axi_wdata,
    input  wire  logic [3:0]  s_axi_wstrb,
    input  wire  logic        s_axi_wvalid,
    output var   logic        s_axi_wready,
    output var   logic [1:0]  s_axi_bresp,
    output var   logic        s_axi_bvalid,
    input  wire  logic        s_axi_bready,
    // axi4-lite read
    input  wire  logic [31:0] s_axi_araddr,
    input  wire  logic        s_axi_arvalid,
    output var   logic        s_axi_arready,
    output var   logic [31:0] s_axi_rdata,
    output var   logic [1:0]  s_axi_rresp,
    output var   logic        s_axi_rvalid,
    input  wire  logic        s_axi_rready,
    // general pin four
    input  wire  logic        general_pin_four_in,
    output var   logic        general_pin_four_out,
    output var   logic        general_pin_four_oe,
    output var   logic        general_pin_four_pullup,
    output var   logic        general_pin_four_analog,
    // transceiver lines
    output var   logic        transceiver_transmit_line,
    output var   logic        transceiver_chip_select_line,
    input  wire  logic        transceiver_receive_line,
    output var   logic [2:0]  transceiver_line_oe,
    output var   logic [2:0]  transceiver_line_pullup,
    // pad controls outside the block
    input  wire  logic        global_pullup_disable,
    output var   logic [3:0]  input_schmitt_sel
);
    // ****************************************
    // configuration registers
    // ****************************************
    fbp_cfg_t    cfg_reg, cfg_next;
    logic [3:0]  sync1_reg, sync2_reg;
    logic [3:0]  pin_in;
    logic [3:0]  port_read;

    // bits 7 and 6 are output-only lines; their read sees the driven latch
    function automatic logic [1:0] lat_view(input logic [3:0] l);
        lat_view = l[3:2];
    endfunction

    assign pin_in = {lat_view(cfg_reg.lat), transceiver_receive_line, general_pin_four_in}; // RULE_02

    // ****************************************
    // axi4-lite handshake state
    // ****************************************
    logic                  aw_hold_reg, aw_hold_next;
    logic                  w_hold_reg, w_hold_next;
    logic [FBP_ADDR_W-1:0] awaddr_reg, awaddr_next;
    logic [3:0]            wdata_reg, wdata_next;
    logic                  wstrb0_reg, wstrb0_next;
    logic                  bvalid_reg, bvalid_next;
    logic [1:0]            bresp_reg, bresp_next;
    logic                  rvalid_reg, rvalid_next;
    logic [31:0]           rdata_reg, rdata_next;
    logic [1:0]            rresp_reg, rresp_next;
    logic                  awready_reg, awready_next;
    logic                  wready_reg, wready_next;
    logic                  arready_reg, arready_next;
    logic                  do_write;

    function automatic logic map_hit(input logic [FBP_ADDR_W-1:0] a);
        map_hit = (a == FBP_OFS_PORT) || (a == FBP_OFS_DIR) || (a == FBP_OFS_LAT)
               || (a == FBP_OFS_ANSEL) || (a == FBP_OFS_PULL) || (a == FBP_OFS_THR);
    endfunction

    always_comb begin
        aw_hold_next = aw_hold_reg;
        w_hold_next  = w_hold_reg;
        awaddr_next  = awaddr_reg;
        wdata_next   = wdata_reg;
        wstrb0_next  = wstrb0_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        // ready is a registered one-cycle pulse; a held channel waits for the response
        awready_next = s_axi_awvalid && !aw_hold_reg && !awready_reg && !bvalid_reg;
        wready_next  = s_axi_wvalid && !w_hold_reg && !wready_reg && !bvalid_reg;
        if (s_axi_awvalid && awready_reg) begin
            aw_hold_next = 1'b1;
            awaddr_next  = s_axi_awaddr[FBP_ADDR_W-1:0];
        end
        if (s_axi_wvalid && wready_reg) begin
            w_hold_next = 1'b1;
            wdata_next  = s_axi_wdata[7:4];
            wstrb0_next = s_axi_wstrb[0];
        end
        do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
        if (do_write) begin
            aw_hold_next = 1'b0;
            w_hold_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = map_hit(awaddr_reg) ? FBP_RESP_OK : FBP_RESP_ERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= 4'h0;
            wstrb0_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= FBP_RESP_OK;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
        end else begin
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            aw_hold_reg <= aw_hold_next;
            w_hold_reg  <= w_hold_next;
            awaddr_reg  <= awaddr_next;
            wdata_reg   <= wdata_next;
            wstrb0_reg  <= wstrb0_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
        end
    end

    // ****************************************
    // register writes
    // ****************************************
    always_comb begin
        cfg_next = cfg_reg;
        if (do_write && wstrb0_reg) begin // RULE_18
            case (awaddr_reg)
                FBP_OFS_PORT:  cfg_next.lat   = wdata_reg; // RULE_07
                FBP_OFS_DIR:   cfg_next.dir   = wdata_reg;
                FBP_OFS_LAT:   cfg_next.lat   = wdata_reg; // RULE_06
                FBP_OFS_ANSEL: cfg_next.ansel = wdata_reg;
                FBP_OFS_PULL:  cfg_next.pull  = wdata_reg;
                FBP_OFS_THR:   cfg_next.thr   = wdata_reg;
                default:       cfg_next       = cfg_reg;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_reg.dir   <= FBP_RST_DIR;
            cfg_reg.lat   <= FBP_RST_LAT;
            cfg_reg.ansel <= FBP_RST_ANSEL; // RULE_10
            cfg_reg.pull  <= FBP_RST_PULL;
            cfg_reg.thr   <= FBP_RST_THR;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // ****************************************
    // input sync and read path
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else begin
            sync1_reg <= pin_in;    // RULE_18
            sync2_reg <= sync1_reg;
        end
    end

    // analog bits read 0; the threshold choice lives in the pad, so both paths read alike
    assign port_read = sync2_reg & ~cfg_reg.ansel; // RULE_08 RULE_12

    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        arready_next = s_axi_arvalid && !arready_reg && !rvalid_reg;
        if (rvalid_reg) begin
            if (s_axi_rready) begin
                rvalid_next = 1'b0;
            end
        end else if (s_axi_arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next  = FBP_RESP_OK;
            case (s_axi_araddr[FBP_ADDR_W-1:0])
                FBP_OFS_PORT:  rdata_next = fbp_word(port_read); // RULE_07 RULE_16
                FBP_OFS_DIR:   rdata_next = fbp_word(cfg_reg.dir);
                FBP_OFS_LAT:   rdata_next = fbp_word(cfg_reg.lat); // RULE_06
                FBP_OFS_ANSEL: rdata_next = fbp_word(cfg_reg.ansel);
                FBP_OFS_PULL:  rdata_next = fbp_word(cfg_reg.pull);
                FBP_OFS_THR:   rdata_next = fbp_word(cfg_reg.thr);
                default: begin
                    rdata_next = 32'h00000000;
                    rresp_next = FBP_RESP_ERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= FBP_RESP_OK;
            arready_reg <= 1'b0;
        end else begin
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            rresp_reg  <= rresp_next;
        end
    end

    // ****************************************
    // pad drive, registered outputs
    // ****************************************
    logic [3:0] oe_reg, out_reg, pull_reg, thr_reg;
    logic       ana_reg;
    logic [3:0] oe_next, pull_next;

    always_comb begin
        // analog select is not looked at here
        oe_next   = ~cfg_next.dir; // RULE_05 RULE_09
        pull_next = cfg_next.pull & cfg_next.dir & {4{~global_pullup_disable}}; // RULE_13 RULE_14
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oe_reg   <= ~FBP_RST_DIR;
            out_reg  <= FBP_RST_LAT;
            pull_reg <= 4'h0;
            thr_reg  <= FBP_RST_THR;
            ana_reg  <= FBP_RST_ANSEL[0];
        end else begin
            oe_reg   <= oe_next;
            out_reg  <= cfg_next.lat;
            pull_reg <= pull_next;
            thr_reg  <= cfg_next.thr; // RULE_15
            ana_reg  <= cfg_next.ansel[0]; // RULE_12
        end
    end

    assign general_pin_four_out         = out_reg[0]; // RULE_01
    assign general_pin_four_oe          = oe_reg[0];
    assign general_pin_four_pullup      = pull_reg[0];
    assign general_pin_four_analog      = ana_reg;
    assign transceiver_transmit_line    = out_reg[3]; // RULE_02
    assign transceiver_chip_select_line = out_reg[2];
    assign transceiver_line_oe          = oe_reg[3:1];
    assign transceiver_line_pullup      = pull_reg[3:1];
    assign input_schmitt_sel            = thr_reg;
    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // ****************************************
    // assertions
    // ****************************************
    sequence latch_commit_s;
        do_write && wstrb0_reg && (awaddr_reg == FBP_OFS_LAT);
    endsequence

    sequence both_held_s;
        aw_hold_reg && w_hold_reg;
    endsequence

    chk_latch_write_lands: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_06
        latch_commit_s |=> (cfg_reg.lat == $past(wdata_reg)))
        else $error("latch write did not land");

    chk_resp_after_both: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_18
        $rose(s_axi_bvalid) |-> $past(aw_hold_reg && w_hold_reg))
        else $error("write response before address and data");

    chk_read_low_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_16
        s_axi_rvalid |-> (s_axi_rdata[3:0] == 4'h0) && (s_axi_rdata[31:8] == 24'h000000))
        else $error("unimplemented read bits not zero");

    chk_pull_off_output: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_14
        general_pin_four_oe |-> !general_pin_four_pullup)
        else $error("pull-up on while pin drives");

    chk_pull_global_off: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_13
        global_pullup_disable |=> !general_pin_four_pullup && (transceiver_line_pullup == 3'h0))
        else $error("pull-up on while globally disabled");

    chk_analog_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_08
        (port_read & cfg_reg.ansel) == 4'h0)
        else $error("analog bit read as one");

    chk_oe_follows_dir: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_05
        (transceiver_line_oe == ~cfg_reg.dir[3:1]) && (general_pin_four_oe == ~cfg_reg.dir[0]))
        else $error("drive enable differs from direction");

    chk_ready_pulse: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_18
        s_axi_arready |=> !s_axi_arready)
        else $error("read ready held over two cycles");
endmodule // fbp_port
`default_nettype wire

// ---- dv/fbp_line_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// transceiver and package pin model
// ****************************************
module fbp_line_model (
    // clock
    input  wire logic aclk,
    // from the port
    input  wire logic pin_out,
    input  wire logic pin_oe,
    input  wire logic pin_pullup,
    input  wire logic tx_line,
    input  wire logic cs_line,
    // bench controls
    input  wire logic ext_en,
    input  wire logic ext_val,
    input  wire logic bus_level,
    // to the port
    output logic      pin_in,
    output logic      rx_line
);
    logic float_q = 1'b0;
    // an undriven pin must not look like a stable level
    always @(posedge aclk) float_q <= ~float_q;
    // driven pin wins, then outside driver, then pull-up
    assign pin_in  = pin_oe ? pin_out : ext_en ? ext_val : pin_pullup ? 1'b1 : float_q;
    // dominant low on transmit loops back to receive while selected
    assign rx_line = cs_line ? (tx_line & bus_level) : 1'b1;
endmodule // fbp_line_model
`default_nettype wire

// ---- dv/test_fbp_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_fbp_port;
    import fbp_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0;
    logic ext_en = 1, ext_val = 0, bus_level = 1, gpd = 0;
    logic awready, wready, bvalid, arready, rvalid, pout, poe, ppu, pan, tx, cs, pin, rx;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] schm;
    int err_total = 0, cmp_count = 0;
    initial forever #10 aclk = ~aclk;
    fbp_port dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .general_pin_four_in(pin),
        .general_pin_four_out(pout), .general_pin_four_oe(poe), .general_pin_four_pullup(ppu),
        .general_pin_four_analog(pan), .transceiver_transmit_line(tx), .transceiver_chip_select_line(cs),
        .transceiver_receive_line(rx), .transceiver_line_oe(), .transceiver_line_pullup(),
        .global_pullup_disable(gpd), .input_schmitt_sel(schm));
    fbp_line_model line_u (.aclk(aclk), .pin_out(pout), .pin_oe(poe), .pin_pullup(ppu), .tx_line(tx),
        .cs_line(cs), .ext_en(ext_en), .ext_val(ext_val), .bus_level(bus_level), .pin_in(pin), .rx_line(rx));
    // ****************************************
    // checking and closing
    // ****************************************
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // ****************************************
    // bus master; ready is looked at mid-cycle, released after the edge
    // ****************************************
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ga, gd, dn;
        ga = 0; gd = 0; dn = 0;
        awaddr <= {27'h0, a}; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (int n = 0; n < 60 && !dn; n++) begin
            @(negedge aclk);
            ga = ga | (awvalid & awready);
            gd = gd | (wvalid & wready);
            dn = bvalid === 1'b1;
            if (dn) chk({30'h0, bresp}, {30'h0, er});
            @(posedge aclk);
            if (ga) awvalid <= 0;
            if (gd) wvalid <= 0;
            if (dn) bready <= 0;
        end
        if (!dn) begin err_total++; close_out(); end
        @(posedge aclk);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ga, dn;
        ga = 0; dn = 0;
        araddr <= {27'h0, a}; arvalid <= 1; rready <= 1;
        for (int n = 0; n < 60 && !dn; n++) begin
            @(negedge aclk);
            ga = ga | (arvalid & arready);
            dn = rvalid === 1'b1;
            if (dn) chk(rdata, e);
            if (dn) chk({30'h0, rresp}, {30'h0, er});
            @(posedge aclk);
            if (ga) arvalid <= 0;
            if (dn) rready <= 0;
        end
        if (!dn) begin err_total++; close_out(); end
        @(posedge aclk);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rd(FBP_OFS_PORT, 32'h00, FBP_RESP_OK);
        rd(FBP_OFS_DIR, 32'hf0, FBP_RESP_OK);
        rd(FBP_OFS_LAT, 32'h00, FBP_RESP_OK);
        rd(FBP_OFS_ANSEL, 32'hf0, FBP_RESP_OK);
        rd(FBP_OFS_PULL, 32'hf0, FBP_RESP_OK);
        rd(FBP_OFS_THR, 32'h00, FBP_RESP_OK);
        rd(5'h1c, 32'h00, FBP_RESP_ERR);
        $display("test reset done");
    endtask
    task automatic t_init();
        wr(FBP_OFS_LAT, 32'hc0, FBP_RESP_OK);
        wr(FBP_OFS_DIR, 32'h3f, FBP_RESP_OK);
        wr(FBP_OFS_ANSEL, 32'h00, FBP_RESP_OK);
        rd(FBP_OFS_DIR, 32'h30, FBP_RESP_OK);
        chk({tx, cs, poe, ppu}, 4'hd);
        gpd <= 1;
        rd(FBP_OFS_LAT, 32'hc0, FBP_RESP_OK);
        chk({31'h0, ppu}, 32'h0);
        gpd <= 0;
        $display("test init done");
    endtask
    task automatic t_levels();
        ext_val <= 1; bus_level <= 1;
        rd(FBP_OFS_THR, 32'h00, FBP_RESP_OK);
        rd(FBP_OFS_PORT, 32'hf0, FBP_RESP_OK);
        ext_val <= 0; bus_level <= 0;
        rd(FBP_OFS_THR, 32'h00, FBP_RESP_OK);
        rd(FBP_OFS_PORT, 32'hc0, FBP_RESP_OK);
        wr(FBP_OFS_PORT, 32'h4f, FBP_RESP_OK);
        rd(FBP_OFS_LAT, 32'h40, FBP_RESP_OK);
        chk({31'h0, tx}, 32'h0);
        $display("test levels done");
    endtask
    task automatic t_analog();
        wr(FBP_OFS_DIR, 32'h20, FBP_RESP_OK);
        wr(FBP_OFS_LAT, 32'h50, FBP_RESP_OK);
        wr(FBP_OFS_ANSEL, 32'h10, FBP_RESP_OK);
        ext_en <= 0;
        rd(FBP_OFS_PORT, 32'h40, FBP_RESP_OK);
        chk({pout, poe, ppu, pan}, 4'hd);
        $display("test analog done");
    endtask
    task automatic t_thresh();
        wr(FBP_OFS_THR, 32'hffffffa5, FBP_RESP_OK);
        rd(FBP_OFS_THR, 32'ha0, FBP_RESP_OK);
        chk({28'h0, schm}, 32'ha);
        wr(FBP_OFS_PULL, 32'h00, FBP_RESP_OK);
        rd(FBP_OFS_PULL, 32'h00, FBP_RESP_OK);
        $display("test threshold done");
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset();
        t_init();
        t_levels();
        t_analog();
        t_thresh();
        close_out();
    end
endmodule // test_fbp_port
`default_nettype wire
